// >>> core/ars_master.sv
/*
 * ars_master: bus-master end of the two-wire register link. Executes one
 * command at a time (start, stop, write byte, read byte) and drives scl
 * from a divider of the system clock.
 * Assumes the user sequences commands legally; no clock stretching.
 */
`timescale 1ns/10ps
module ars_master #(
    parameter int STD_Q = ars_pkg::STD_QTR, // quarter period, standard
    parameter int FAST_Q = ars_pkg::FAST_QTR, // quarter period, fast
    parameter int HS_Q = ars_pkg::HS_QTR // quarter period, high speed
) (
    input wire logic mclk_i, // system clock
    input wire logic srst_i, // sync reset, high
    ars_i2c_if.master bus, // link wires
    input wire logic cmd_valid_i, // command request
    input wire ars_pkg::ars_cmd_t cmd_i, // command code
    input wire logic [ars_pkg::BYTE_W-1:0] cmd_data_i, // byte to write
    input wire logic cmd_mack_i, // read: answer with ack
    input wire logic fast_i, // 400 kHz instead of 100 kHz
    output logic cmd_ready_o, // idle, command taken
    output logic done_o, // one-cycle completion pulse
    output logic [ars_pkg::BYTE_W-1:0] rd_data_o, // byte read
    output logic slave_ack_o, // write: slave acked
    output logic hs_mode_o // running at high speed
);
    import ars_pkg::*;

    typedef enum logic [3:0] {
        M_IDLE = 4'h1,
        M_START = 4'h2,
        M_STOP = 4'h4,
        M_BYTE = 4'h8
    } ars_mstate_t;

    // ------------------------------------------------------------------
    // sda synchroniser and quarter-period divider
    // ------------------------------------------------------------------
    logic sda_s1_reg, sda_s2_reg;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
        end else begin
            sda_s1_reg <= bus.sda;
            sda_s2_reg <= sda_s1_reg;
        end
    end

    ars_mstate_t state_reg;
    logic [QTR_W-1:0] div_reg;
    logic [QTR_W-1:0] qlen;
    logic tick;
    assign qlen = hs_mode_o ? QTR_W'(HS_Q - 1) : (fast_i ? QTR_W'(FAST_Q - 1) : QTR_W'(STD_Q - 1));
    assign tick = (state_reg != M_IDLE) && (div_reg == '0);

    always_ff @(posedge mclk_i) begin
        if (srst_i || state_reg == M_IDLE || tick) begin
            div_reg <= qlen;
        end else begin
            div_reg <= div_reg - 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------------
    logic [1:0] qtr_reg;
    logic [3:0] bitn_reg;
    logic [BYTE_W-1:0] byte_reg;
    logic [BYTE_W-1:0] sh_reg;
    logic is_read_reg, mack_reg;
    logic scl_oe_n_reg, sda_oe_n_reg;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_reg <= M_IDLE;
            qtr_reg <= 2'h0;
            bitn_reg <= 4'h0;
            byte_reg <= 8'h00;
            sh_reg <= 8'h00;
            is_read_reg <= 1'b0;
            mack_reg <= 1'b0;
            scl_oe_n_reg <= 1'b1;
            sda_oe_n_reg <= 1'b1;
            cmd_ready_o <= 1'b1;
            done_o <= 1'b0;
            rd_data_o <= 8'h00;
            slave_ack_o <= 1'b0;
            hs_mode_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (state_reg)
                M_IDLE: begin
                    if (cmd_valid_i) begin
                        cmd_ready_o <= 1'b0;
                        qtr_reg <= 2'h0;
                        bitn_reg <= 4'h0;
                        byte_reg <= cmd_data_i;
                        sh_reg <= cmd_data_i;
                        is_read_reg <= (cmd_i == CMD_READ);
                        mack_reg <= cmd_mack_i;
                        case (cmd_i)
                            CMD_START: state_reg <= M_START;
                            CMD_STOP: state_reg <= M_STOP;
                            default: state_reg <= M_BYTE;
                        endcase
                    end
                end
                M_START: begin
                    if (tick) begin
                        qtr_reg <= qtr_reg + 2'h1;
                        case (qtr_reg)
                            2'h0: sda_oe_n_reg <= 1'b1;
                            2'h1: scl_oe_n_reg <= 1'b1;
                            2'h2: sda_oe_n_reg <= 1'b0;
                            default: begin
                                scl_oe_n_reg <= 1'b0;
                                state_reg <= M_IDLE;
                                cmd_ready_o <= 1'b1;
                                done_o <= 1'b1;
                            end
                        endcase
                    end
                end
                M_STOP: begin
                    if (tick) begin
                        qtr_reg <= qtr_reg + 2'h1;
                        case (qtr_reg)
                            2'h0: sda_oe_n_reg <= 1'b0;
                            2'h1: scl_oe_n_reg <= 1'b1;
                            2'h2: sda_oe_n_reg <= 1'b1;
                            default: begin
                                hs_mode_o <= 1'b0;
                                state_reg <= M_IDLE;
                                cmd_ready_o <= 1'b1;
                                done_o <= 1'b1;
                            end
                        endcase
                    end
                end
                M_BYTE: begin
                    if (tick) begin
                        qtr_reg <= qtr_reg + 2'h1;
                        case (qtr_reg)
                            2'h0: begin
                                // drive only zeros; a one is a released line
                                if (bitn_reg != 4'(BITS_PER_SLOT)) begin
                                    sda_oe_n_reg <= is_read_reg | sh_reg[7];
                                end else begin
                                    sda_oe_n_reg <= ~is_read_reg | ~mack_reg;
                                end
                            end
                            2'h1: scl_oe_n_reg <= 1'b1;
                            2'h2: begin
                                if (bitn_reg != 4'(BITS_PER_SLOT)) begin
                                    rd_data_o <= {rd_data_o[6:0], sda_s2_reg};
                                end else begin
                                    slave_ack_o <= ~sda_s2_reg;
                                end
                            end
                            default: begin
                                scl_oe_n_reg <= 1'b0;
                                // hand sda over as scl falls: the slave pulls it a few
                                // cycles later, so holding on would double-drive the line
                                if (is_read_reg ? bitn_reg == 4'(BITS_PER_SLOT)
                                    : bitn_reg == 4'(BITS_PER_SLOT - 1)) begin
                                    sda_oe_n_reg <= 1'b1;
                                end
                                sh_reg <= {sh_reg[6:0], 1'b0};
                                bitn_reg <= bitn_reg + 4'h1;
                                if (bitn_reg == 4'(BITS_PER_SLOT)) begin
                                    // master code answered with nack: speed up
                                    if (!is_read_reg && !slave_ack_o
                                        && byte_reg[7:3] == HS_CODE_TOP) begin
                                        hs_mode_o <= 1'b1;
                                    end
                                    state_reg <= M_IDLE;
                                    cmd_ready_o <= 1'b1;
                                    done_o <= 1'b1;
                                end
                            end
                        endcase
                    end
                end
                default: state_reg <= M_IDLE;
            endcase
        end
    end

    assign bus.m_scl_o = 1'b0;
    assign bus.m_scl_oe_n = scl_oe_n_reg;
    assign bus.m_sda_o = 1'b0;
    assign bus.m_sda_oe_n = sda_oe_n_reg;
endmodule // ars_master

// >>> core/ars_slave.sv
/*
 * ars_slave: device end of the two-wire register link. Detects start,
 * repeated start and stop, matches the target address, takes pointer and
 * data-byte pairs, and returns the pointed register in byte pairs.
 * Assumes the register bank outside answers rd_data_i for ptr_o
 * combinationally in the same clock domain.
 */
// Notes on behaviour
// - drive low only, release for one
// - all rates share one protocol engine
// - start then seven-bit address plus direction
// - ack own address, release otherwise
// - first written byte loads pointer, acked
// - msb then lsb data, each acked
// - master stops after msb for one byte
// - after lsb: more pairs, restart or stop
// - read sends pointed msb at once
// - master ack gets lsb, nack ends
// - one-byte read: master nacks then stops
// - acked lsb resends msb, unbounded
// - master sets pointer before other read
// - repeated start keeps speed mode
// - stop ends transfer, bus idles
// - master code is not acknowledged
// - restart after master code enters high speed
// - stop leaves high speed mode
// - writes load pointer, reads reuse it
// - fixed target address by default
`timescale 1ns/10ps
module ars_slave #(
    parameter logic [6:0] OWN_ADDR = ars_pkg::DEV_ADDR
) (
    input wire logic mclk_i, // system clock
    input wire logic srst_i, // sync reset, high
    ars_i2c_if.slave bus, // link wires
    input wire logic [ars_pkg::WORD_W-1:0] rd_data_i, // word at ptr_o
    output logic [ars_pkg::BYTE_W-1:0] ptr_o, // register pointer
    output logic [ars_pkg::WORD_W-1:0] wr_data_o, // written word
    output logic wr_stb_o, // one-cycle write pulse
    output logic hs_mode_o // high-speed mode active
);
    import ars_pkg::*;

    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_RX = 5'h02,
        S_RACK = 5'h04,
        S_TX = 5'h08,
        S_TACK = 5'h10
    } ars_sstate_t;

    typedef enum logic [3:0] {
        K_ADDR = 4'h1,
        K_PTR = 4'h2,
        K_MSB = 4'h4,
        K_LSB = 4'h8
    } ars_kind_t;

    // ------------------------------------------------------------------
    // input synchronisers and edge detection
    // ------------------------------------------------------------------
    logic scl_s1_reg, scl_s2_reg, scl_d_reg;
    logic sda_s1_reg, sda_s2_reg, sda_d_reg;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            scl_s1_reg <= 1'b1;
            scl_s2_reg <= 1'b1;
            scl_d_reg <= 1'b1;
            sda_s1_reg <= 1'b1;
            sda_s2_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_s1_reg <= bus.scl;
            scl_s2_reg <= scl_s1_reg;
            scl_d_reg <= scl_s2_reg;
            sda_s1_reg <= bus.sda;
            sda_s2_reg <= sda_s1_reg;
            sda_d_reg <= sda_s2_reg;
        end
    end

    logic scl_rise, scl_fall, start_det, stop_det;
    assign scl_rise = scl_s2_reg & ~scl_d_reg;
    assign scl_fall = ~scl_s2_reg & scl_d_reg;
    // data may only move while scl is low, so sda edges under high scl frame
    assign start_det = scl_s2_reg & scl_d_reg & sda_d_reg & ~sda_s2_reg;
    assign stop_det = scl_s2_reg & scl_d_reg & ~sda_d_reg & sda_s2_reg;

    // ------------------------------------------------------------------
    // byte framing
    // ------------------------------------------------------------------
    ars_sstate_t state_reg;
    ars_kind_t kind_reg;
    logic [3:0] bit_cnt_reg;
    logic [BYTE_W-1:0] rx_reg;
    logic [BYTE_W-1:0] tx_reg;
    logic [BYTE_W-1:0] lsb_hold_reg;
    logic rd_mode_reg;
    logic send_lsb_reg;
    logic m_ack_reg;
    logic sda_oe_n_reg;

    logic byte_done, addr_hit, code_hit;
    assign byte_done = (state_reg == S_RX) && scl_fall && (bit_cnt_reg == 4'(BITS_PER_SLOT));
    assign addr_hit = (kind_reg == K_ADDR) && (rx_reg[7:1] == OWN_ADDR);
    assign code_hit = (kind_reg == K_ADDR) && (rx_reg[7:3] == HS_CODE_TOP);

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            state_reg <= S_IDLE;
            kind_reg <= K_ADDR;
            bit_cnt_reg <= 4'h0;
            rx_reg <= 8'h00;
            tx_reg <= 8'h00;
            lsb_hold_reg <= 8'h00;
            rd_mode_reg <= 1'b0;
            send_lsb_reg <= 1'b0;
            m_ack_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
        end else if (start_det) begin
            state_reg <= S_RX;
            kind_reg <= K_ADDR;
            bit_cnt_reg <= 4'h0;
            rd_mode_reg <= 1'b0;
            sda_oe_n_reg <= 1'b1;
        end else if (stop_det) begin
            state_reg <= S_IDLE;
            sda_oe_n_reg <= 1'b1;
        end else begin
            case (state_reg)
                S_RX: begin
                    if (scl_rise) begin
                        rx_reg <= {rx_reg[6:0], sda_s2_reg};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    end else if (byte_done) begin
                        if (kind_reg != K_ADDR || addr_hit) begin
                            // pull low through the ack slot
                            sda_oe_n_reg <= 1'b0;
                            state_reg <= S_RACK;
                        end else begin
                            // foreign address or master code: leave sda released
                            state_reg <= S_IDLE;
                        end
                        case (kind_reg)
                            K_ADDR: begin
                                rd_mode_reg <= rx_reg[0];
                                kind_reg <= K_PTR;
                            end
                            K_PTR: kind_reg <= K_MSB;
                            K_MSB: kind_reg <= K_LSB;
                            default: kind_reg <= K_MSB;
                        endcase
                    end
                end
                S_RACK: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        if (rd_mode_reg) begin
                            // read starts with the msb of the pointed word
                            tx_reg <= rd_data_i[15:8];
                            lsb_hold_reg <= rd_data_i[7:0];
                            sda_oe_n_reg <= rd_data_i[15];
                            send_lsb_reg <= 1'b1;
                            state_reg <= S_TX;
                        end else begin
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= S_RX;
                        end
                    end
                end
                S_TX: begin
                    if (scl_fall) begin
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        if (bit_cnt_reg == 4'(BITS_PER_SLOT - 1)) begin
                            sda_oe_n_reg <= 1'b1;
                            state_reg <= S_TACK;
                        end else begin
                            tx_reg <= {tx_reg[6:0], 1'b0};
                            sda_oe_n_reg <= tx_reg[6];
                        end
                    end
                end
                S_TACK: begin
                    if (scl_rise) begin
                        m_ack_reg <= ~sda_s2_reg;
                    end else if (scl_fall) begin
                        bit_cnt_reg <= 4'h0;
                        if (!m_ack_reg) begin
                            state_reg <= S_IDLE;
                        end else if (send_lsb_reg) begin
                            tx_reg <= lsb_hold_reg;
                            sda_oe_n_reg <= lsb_hold_reg[7];
                            send_lsb_reg <= 1'b0;
                            state_reg <= S_TX;
                        end else begin
                            // same pointer again, word refreshed per pair
                            tx_reg <= rd_data_i[15:8];
                            lsb_hold_reg <= rd_data_i[7:0];
                            sda_oe_n_reg <= rd_data_i[15];
                            send_lsb_reg <= 1'b1;
                            state_reg <= S_TX;
                        end
                    end
                end
                default: begin
                    sda_oe_n_reg <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // pointer and write data
    // ------------------------------------------------------------------
    logic [BYTE_W-1:0] msb_reg;

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            ptr_o <= 8'h00;
            msb_reg <= 8'h00;
            wr_data_o <= 16'h0000;
            wr_stb_o <= 1'b0;
        end else begin
            wr_stb_o <= 1'b0;
            if (byte_done && kind_reg == K_PTR) begin
                ptr_o <= rx_reg;
            end
            if (byte_done && kind_reg == K_MSB) begin
                msb_reg <= rx_reg;
            end
            // a lone msb followed by stop writes nothing
            if (byte_done && kind_reg == K_LSB) begin
                wr_data_o <= {msb_reg, rx_reg};
                wr_stb_o <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // speed mode tracking
    // ------------------------------------------------------------------
    logic hs_arm_reg;

    always_ff @(posedge mclk_i) begin
        if (srst_i || stop_det) begin
            hs_mode_o <= 1'b0;
            hs_arm_reg <= 1'b0;
        end else if (start_det && hs_arm_reg) begin
            hs_mode_o <= 1'b1;
            hs_arm_reg <= 1'b0;
        end else if (byte_done && code_hit) begin
            hs_arm_reg <= 1'b1;
        end
    end
    // no timing depends on the mode: sampling is edge driven at every rate

    assign bus.s_scl_o = 1'b0;
    assign bus.s_scl_oe_n = 1'b1;
    assign bus.s_sda_o = 1'b0;
    assign bus.s_sda_oe_n = sda_oe_n_reg;
endmodule // ars_slave

// >>> include/ars_i2c_if.sv
/*
 * ars_i2c_if: the two open-drain wires between master and slave end.
 * Each end drives only a low level through its enable; the wire level
 * stands for the external pull-up.
 */
`timescale 1ns/10ps
interface ars_i2c_if;
    logic m_scl_o;
    logic m_scl_oe_n;
    logic m_sda_o;
    logic m_sda_oe_n;
    logic s_scl_o;
    logic s_scl_oe_n;
    logic s_sda_o;
    logic s_sda_oe_n;
    logic scl;
    logic sda;

    // wired-and with pull-up: a released line reads high
    assign scl = (m_scl_oe_n | m_scl_o) & (s_scl_oe_n | s_scl_o);
    assign sda = (m_sda_oe_n | m_sda_o) & (s_sda_oe_n | s_sda_o);

    modport master (input scl, input sda,
        output m_scl_o, output m_scl_oe_n, output m_sda_o, output m_sda_oe_n);
    modport slave (input scl, input sda,
        output s_scl_o, output s_scl_oe_n, output s_sda_o, output s_sda_oe_n);
endinterface // ars_i2c_if

// >>> include/ars_pkg.sv
/*
 * ars_pkg: constants and types shared by both ends of the two-wire
 * register link (target address, master-code pattern, rates, command codes).
 * Assumes a single 100 MHz system clock in each end.
 */
package ars_pkg;
    // ------------------------------------------------------------------
    // clock and link rates
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 100_000_000;
    localparam int STD_HZ = 100_000;
    localparam int FAST_HZ = 400_000;
    localparam int HS_HZ = 3_400_000;
    // quarter of an scl period in cycles; high speed is rounded up so its rate is never exceeded,
    // fast is truncated (62.5 to 62), so its rate is slightly exceeded
    localparam int STD_QTR = CLK_HZ / (4 * STD_HZ);
    localparam int FAST_QTR = CLK_HZ / (4 * FAST_HZ);
    localparam int HS_QTR = (CLK_HZ + 4 * HS_HZ - 1) / (4 * HS_HZ);
    localparam int QTR_W = 9;

    // ------------------------------------------------------------------
    // protocol fields
    // ------------------------------------------------------------------
    localparam int BYTE_W = 8;
    localparam int WORD_W = 16;
    localparam int BITS_PER_SLOT = 8;
    localparam logic [6:0] DEV_ADDR = 7'h54;
    localparam logic [4:0] HS_CODE_TOP = 5'h01;

    // ------------------------------------------------------------------
    // master command codes, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CMD_START = 4'h1,
        CMD_STOP = 4'h2,
        CMD_WRITE = 4'h4,
        CMD_READ = 4'h8
    } ars_cmd_t;
endpackage

// >>> verif/ars_link_asserts.sv
/* ars_link_asserts: wire-level checks of the two-wire link.
   assumes the ars_i2c_if signals of one link and a single clock domain. */
`timescale 1ns/10ps
module ars_link_asserts (
    input wire logic mclk_i, // system clock
    input wire logic srst_i, // sync reset, high
    input wire logic m_scl_o, // master scl value
    input wire logic m_scl_oe_n, // master scl enable
    input wire logic m_sda_o, // master sda value
    input wire logic m_sda_oe_n, // master sda enable
    input wire logic s_scl_oe_n, // slave scl enable
    input wire logic s_sda_o, // slave sda value
    input wire logic s_sda_oe_n, // slave sda enable
    input wire logic scl, // resolved scl
    input wire logic sda // resolved sda
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    // ------------------------------------------------------------
    // drive rules
    // ------------------------------------------------------------
    a_low_only_drive: assert property (!m_scl_o && !m_sda_o && !s_sda_o)
        else $error("a link end drives a line high");
    a_no_stretch: assert property (s_scl_oe_n)
        else $error("slave pulls scl");
    a_reset_released: assert property (disable iff (1'b0) srst_i |=> s_sda_oe_n && m_sda_oe_n && m_scl_oe_n)
        else $error("line held during reset");
    a_no_contention: assert property (!(!s_sda_oe_n && !m_sda_oe_n))
        else $error("both ends pull sda");
    // ------------------------------------------------------------
    // framing
    // ------------------------------------------------------------
    // a slave edge under high scl would read as a false start or stop
    a_slave_sda_stable: assert property ($changed(s_sda_oe_n) |-> !scl)
        else $error("slave moves sda while scl high");
    a_start_hold: assert property (scl && $fell(sda) |-> scl [*4])
        else $error("scl drops too soon after start");
    a_stop_idle: assert property (scl && $rose(sda) |=> sda [*4])
        else $error("bus not idle after stop");
    a_ack_hold: assert property ($rose(scl) && !s_sda_oe_n |-> !s_sda_oe_n [*4])
        else $error("slave bit not held over scl high");
    c_start: cover property (scl && $fell(sda));
    c_stop: cover property (scl && $rose(sda));
    c_slave_low: cover property ($rose(scl) && !s_sda_oe_n);
endmodule // ars_link_asserts

// >>> verif/ars_slave_tb.sv
/* ars_slave_tb: master and slave ends joined over one link, register bank
   behind the slave, integer model of the registers.
   assumes ars_pkg, ars_i2c_if and both ends compiled first. */
`timescale 1ns/10ps
module ars_slave_tb;
    import ars_pkg::*;
    logic mclk_i = 0, srst_i = 1, cmd_valid_i = 0, cmd_mack_i = 0, fast_i = 0;
    ars_cmd_t cmd_i = CMD_STOP;
    logic [7:0] cmd_data_i = 8'h00, ptr_o, rd_data_o, p, q;
    logic [15:0] rd_data_i, wr_data_o;
    logic wr_stb_o, s_hs, m_hs, cmd_ready_o, done_o, slave_ack_o;
    logic [15:0] bank [256];
    int exp_mem [256];
    int error_cnt = 0, comparisons = 0;
    ars_i2c_if link_if ();
    ars_slave ars_slave_inst (.mclk_i, .srst_i, .bus(link_if), .rd_data_i, .ptr_o,
        .wr_data_o, .wr_stb_o, .hs_mode_o(s_hs));
    // short quarters keep the run brief; all timing is relative
    ars_master #(.STD_Q(12), .FAST_Q(8), .HS_Q(6)) ars_master_inst (.mclk_i, .srst_i,
        .bus(link_if), .cmd_valid_i, .cmd_i, .cmd_data_i, .cmd_mack_i, .fast_i,
        .cmd_ready_o, .done_o, .rd_data_o, .slave_ack_o, .hs_mode_o(m_hs));
    ars_link_asserts ars_link_asserts_inst (.mclk_i, .srst_i,
        .m_scl_o(link_if.m_scl_o), .m_scl_oe_n(link_if.m_scl_oe_n),
        .m_sda_o(link_if.m_sda_o), .m_sda_oe_n(link_if.m_sda_oe_n),
        .s_scl_oe_n(link_if.s_scl_oe_n), .s_sda_o(link_if.s_sda_o),
        .s_sda_oe_n(link_if.s_sda_oe_n), .scl(link_if.scl), .sda(link_if.sda));
    assign rd_data_i = bank[ptr_o];
    always @(posedge mclk_i) if (wr_stb_o) bank[ptr_o] <= wr_data_o;
    initial forever #5 mclk_i = ~mclk_i;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cmd(ars_cmd_t c, logic [7:0] d = 8'h00, logic mk = 1'b0);
        int n;
        @(negedge mclk_i);
        cmd_valid_i = 1'b1;
        cmd_i = c;
        cmd_data_i = d;
        cmd_mack_i = mk;
        @(negedge mclk_i);
        cmd_valid_i = 1'b0;
        for (n = 0; n < 2000 && done_o !== 1'b1; n++) @(negedge mclk_i);
        if (n == 2000) error_cnt++;
        chk("ready", cmd_ready_o, 16'h0001);
    endtask
    task automatic sel(logic rw);
        cmd(CMD_START);
        cmd(CMD_WRITE, {DEV_ADDR, rw});
        chk("addr ack", slave_ack_o, 16'h0001);
    endtask
    task automatic wb(logic [7:0] d);
        cmd(CMD_WRITE, d);
        chk("byte ack", slave_ack_o, 16'h0001);
    endtask
    task automatic wr(logic [7:0] a, int pairs);
        logic [15:0] w;
        sel(1'b0);
        wb(a);
        repeat (pairs) begin
            w = 16'($urandom);
            wb(w[15:8]);
            wb(w[7:0]);
            exp_mem[a] = w;
        end
        cmd(CMD_STOP);
        chk("pointer", ptr_o, a);
        chk("word", wr_data_o, 16'(exp_mem[a]));
    endtask
    task automatic rd(logic [7:0] a, int n);
        for (int i = 0; i < n; i++) begin
            cmd(CMD_READ, 8'h00, i < n - 1);
            chk("read", rd_data_o, 16'(i % 2 ? exp_mem[a] & 16'h00ff : exp_mem[a] >> 8));
        end
        cmd(CMD_STOP);
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        foreach (bank[i]) bank[i] = 16'h0000;
        void'($urandom(32'hb6de_f449));
        repeat (2) @(negedge mclk_i);
        srst_i = 1'b0;
        for (int f = 0; f < 2; f++) begin
            fast_i = f[0];
            p = 8'($urandom);
            q = p ^ 8'h01;
            wr(p, 2);
            sel(1'b1);
            rd(p, 5);
            $display("test write and read done");
            cmd(CMD_START);
            cmd(CMD_WRITE, {DEV_ADDR ^ 7'h01, 1'b0});
            chk("foreign ack", slave_ack_o, 16'h0000);
            cmd(CMD_WRITE, 8'h5a);
            cmd(CMD_STOP);
            chk("pointer kept", ptr_o, p);
            wr(q, 1);
            sel(1'b0);
            wb(p);
            wb(8'h33);
            cmd(CMD_STOP);
            chk("lone msb", wr_data_o, 16'(exp_mem[q]));
            sel(1'b0);
            wb(q);
            sel(1'b1);
            rd(q, 1);
            $display("test address and pointer done");
            cmd(CMD_START);
            cmd(CMD_WRITE, {HS_CODE_TOP, 3'($urandom)});
            chk("code nack", slave_ack_o, 16'h0000);
            sel(1'b0);
            chk("hs entered", {m_hs, s_hs}, 16'h0003);
            wb(q);
            wb(8'hc3);
            wb(8'h3c);
            exp_mem[q] = 16'hc33c;
            sel(1'b1);
            chk("hs kept", {m_hs, s_hs}, 16'h0003);
            rd(q, 3);
            chk("hs left", {m_hs, s_hs}, 16'h0000);
            $display("test high speed done");
        end
        print_verdict();
    end
    initial begin
        repeat (60000) @(posedge mclk_i);
        error_cnt++;
        print_verdict();
    end
endmodule // ars_slave_tb
